/* File: src/pcrb_top.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pcrb_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic setting_pin_zero,
  input wire logic setting_pin_one,
  input wire logic setting_pin_two,
  output logic [29:0] loop1_alt_word_q,
  output logic [1:0] loop1_alt_vco_band_q,
  output logic [7:0] loop1_alt_vco_min_mhz_q,
  output logic [2:0] loop2_spread_amount_q,
  output logic loop2_spread_shape_q,
  output logic [7:0] loop2_spread_quarter_pct_q,
  output logic loop2_freq_choice_q,
  output logic loop2_bypass_sel_q,
  output logic loop2_powered_q,
  output logic [3:0] out4_source_q,
  output logic [3:0] out5_source_q,
  output logic [3:0] pair_state_q,
  output logic pair_drive_en_q,
  output logic pair_drive_low_q
);
  pcrb_cfg_if cfg ();

  logic [11:0] awaddr_q;
  logic aw_held_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic w_held_q;
  logic rd_pend_q;
  logic wr_en;
  logic wr_hit;
  logic rd_hit_q;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [7:0] rd_byte;
  logic [29:0] alt_word;
  logic [1:0] alt_band;
  logic [2:0] spread_amount;
  logic freq_choice;
  logic [1:0] active_state;
  logic [7:0] mux_r;

  // Printed offsets are not word aligned, so each offset is an index at four times its value.
  function automatic logic [3:0] to_idx(input logic [11:0] a);
    logic [9:0] w;
    w = a[11:2] - 10'(pcrb_pkg::FIRST_IDX);
    return w[3:0];
  endfunction

  function automatic logic hit(input logic [11:0] a);
    logic [9:0] w;
    w = a[11:2] - 10'(pcrb_pkg::FIRST_IDX);
    return a[1:0] == 2'b00 && a[11:2] >= 10'(pcrb_pkg::FIRST_IDX) &&
      w < 10'(pcrb_pkg::NUM_REGS);
  endfunction

  assign cfg.setting = {setting_pin_two, setting_pin_one, setting_pin_zero};
  assign wr_idx = to_idx(awaddr_q);
  assign wr_hit = hit(awaddr_q);
  // The byte is fetched on the address handshake, so it is waiting when the answer goes out.
  assign rd_idx = hit(s_axi_araddr) ? to_idx(s_axi_araddr) : 4'hF;
  // A write happens once both halves are held, no response is waiting, the address hits and strobe bit 0 is set.
  assign wr_en = aw_held_q && w_held_q && !s_axi_bvalid && wr_hit && wstrb0_q;

  pcrb_regfile u_regs (
    .clk(clk),
    .srst(srst),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wdata_q),
    .rd_idx(rd_idx),
    .rd_data_q(rd_byte),
    .cfg(cfg)
  );

  pcrb_decode u_dec (
    .cfg(cfg),
    .alt_word(alt_word),
    .alt_band(alt_band),
    .spread_amount(spread_amount),
    .freq_choice(freq_choice),
    .state_choice(),
    .active_state(active_state)
  );

  // Each half of a write is held until its response is taken, so either may come first.
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      w_held_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_q <= 1'b0;
    end
  end

  // Ready drops right after a handshake, which keeps the slave to one write at a time.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Unmapped or misaligned writes are dropped and answered with SLVERR.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcrb_pkg::RESP_OKAY;
    end else if (s_axi_bvalid) begin
      if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end else if (aw_held_q && w_held_q) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? pcrb_pkg::RESP_OKAY : pcrb_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_hit_q <= 1'b0;
    end else begin
      s_axi_arready <= !rd_pend_q && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_q <= 1'b1;
        rd_hit_q <= hit(s_axi_araddr);
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (rd_pend_q) begin
      s_axi_rvalid <= 1'b1;
    end
  end

  // Payload loads only with a new answer and holds while the master stalls.
  // Unmapped reads return zero data, since the register file reads nothing for them.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pcrb_pkg::RESP_OKAY;
    end else if (rd_pend_q && !s_axi_rvalid) begin
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit_q ? pcrb_pkg::RESP_OKAY : pcrb_pkg::RESP_SLVERR;
    end
  end

  assign mux_r = cfg.regs[8];

  always_ff @(posedge clk) begin
    if (srst) begin
      loop1_alt_word_q <= 30'h0000_0000;
      loop1_alt_vco_band_q <= 2'h0;
      loop1_alt_vco_min_mhz_q <= 8'h00;
    end else begin
      loop1_alt_word_q <= alt_word;
      loop1_alt_vco_band_q <= alt_band;
      unique case (alt_band)
        2'h0: loop1_alt_vco_min_mhz_q <= 8'h00;
        2'h1: loop1_alt_vco_min_mhz_q <= 8'h7D;
        2'h2: loop1_alt_vco_min_mhz_q <= 8'h96;
        2'h3: loop1_alt_vco_min_mhz_q <= 8'hAF;
      endcase
    end
  end

  // Amount in quarter percent; the top code jumps to 2.0 percent. Shape only
  // decides whether the deviation is one-sided or symmetric.
  always_ff @(posedge clk) begin
    if (srst) begin
      loop2_spread_amount_q <= 3'h0;
      loop2_spread_shape_q <= 1'b0;
      loop2_spread_quarter_pct_q <= 8'h00;
      loop2_freq_choice_q <= 1'b0;
    end else begin
      loop2_spread_amount_q <= spread_amount;
      loop2_spread_shape_q <= cfg.regs[10][pcrb_pkg::SHAPE_BIT];
      loop2_spread_quarter_pct_q <= (spread_amount == 3'h7) ? 8'h08
                                    : {5'h00, spread_amount};
      loop2_freq_choice_q <= freq_choice;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop2_bypass_sel_q <= 1'b1;
    end else begin
      loop2_bypass_sel_q <= mux_r[pcrb_pkg::BYPASS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out4_source_q <= pcrb_pkg::SRC_DIV_FOUR;
    end else begin
      out4_source_q <= mux_r[pcrb_pkg::OUT4_SEL_BIT] ? pcrb_pkg::SRC_DIV_FOUR
                                                     : pcrb_pkg::SRC_DIV_TWO;
    end
  end

  // The reserved code is stored as written and shown as no source, not refused.
  always_ff @(posedge clk) begin
    if (srst) begin
      out5_source_q <= pcrb_pkg::SRC_DIV_FIVE;
    end else begin
      unique case (mux_r[pcrb_pkg::OUT5_SEL_LSB +: 2])
        2'h0: out5_source_q <= pcrb_pkg::SRC_DIV_TWO;
        2'h1: out5_source_q <= pcrb_pkg::SRC_DIV_FOUR;
        2'h2: out5_source_q <= pcrb_pkg::SRC_DIV_FIVE;
        pcrb_pkg::OUT5_RESERVED: out5_source_q <= pcrb_pkg::SRC_NONE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pair_state_q <= pcrb_pkg::ST_HIZ_RUN;
      pair_drive_en_q <= 1'b0;
      pair_drive_low_q <= 1'b0;
    end else begin
      unique case (active_state)
        2'h0: pair_state_q <= pcrb_pkg::ST_HIZ_DOWN;
        2'h1: pair_state_q <= pcrb_pkg::ST_HIZ_RUN;
        2'h2: pair_state_q <= pcrb_pkg::ST_LOW_RUN;
        2'h3: pair_state_q <= pcrb_pkg::ST_ENABLED;
      endcase
      pair_drive_en_q <= active_state[1];
      pair_drive_low_q <= active_state == 2'h2;
    end
  end

  // Loop power is off when bypassed or when the chosen state asks for it.
  always_ff @(posedge clk) begin
    if (srst) begin
      loop2_powered_q <= 1'b0;
    end else begin
      loop2_powered_q <= !mux_r[pcrb_pkg::BYPASS_BIT] && active_state != 2'h0;
    end
  end
endmodule

/* File: src/pcrb_pkg.sv */
package pcrb_pkg;
  localparam logic [11:0] OFF_ALT_N_HI = 12'h01C;
  localparam logic [11:0] OFF_ALT_N_LO_R_HI = 12'h01D;
  localparam logic [11:0] OFF_ALT_R_LO_Q_HI = 12'h01E;
  localparam logic [11:0] OFF_ALT_Q_LO_P_BAND = 12'h01F;
  localparam logic [11:0] OFF_SPREAD_A = 12'h020;
  localparam logic [11:0] OFF_SPREAD_B = 12'h021;
  localparam logic [11:0] OFF_SPREAD_C = 12'h022;
  localparam logic [11:0] OFF_FREQ_SEL = 12'h023;
  localparam logic [11:0] OFF_MUX_STATES = 12'h024;
  localparam logic [11:0] OFF_STATE_CHOICE = 12'h025;
  localparam logic [11:0] OFF_SPREAD_SHAPE = 12'h026;
  localparam int NUM_REGS = 11;
  localparam int FIRST_IDX = 28;
  localparam logic [7:0] RST_ALT_N_HI = 8'h00;
  localparam logic [7:0] RST_ALT_N_LO_R_HI = 8'h40;
  localparam logic [7:0] RST_ALT_R_LO_Q_HI = 8'h02;
  localparam logic [7:0] RST_ALT_Q_LO_P_BAND = 8'h08;
  localparam logic [7:0] RST_SPREAD = 8'h00;
  localparam logic [7:0] RST_FREQ_SEL = 8'h00;
  localparam logic [7:0] RST_MUX_STATES = 8'hED;
  localparam logic [7:0] RST_STATE_CHOICE = 8'h02;
  localparam logic [7:0] RST_SPREAD_SHAPE = 8'h00;
  localparam int BYPASS_BIT = 7;
  localparam int OUT4_SEL_BIT = 6;
  localparam int OUT5_SEL_LSB = 4;
  localparam int STATE_ONE_LSB = 2;
  localparam int STATE_ZERO_LSB = 0;
  localparam int SHAPE_BIT = 7;
  localparam logic [1:0] OUT5_RESERVED = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_HIZ_DOWN = 4'h1,
    ST_HIZ_RUN = 4'h2,
    ST_LOW_RUN = 4'h4,
    ST_ENABLED = 4'h8
  } pcrb_out_state_t;
  typedef enum logic [3:0] {
    SRC_DIV_TWO = 4'h1,
    SRC_DIV_FOUR = 4'h2,
    SRC_DIV_FIVE = 4'h4,
    SRC_NONE = 4'h8
  } pcrb_src_t;
endpackage

/* File: src/pcrb_cfg_if.sv */
`timescale 1ns/1ps
interface pcrb_cfg_if;
  logic [7:0] regs [pcrb_pkg::NUM_REGS];
  logic [2:0] setting;
  modport bank (output regs);
  modport dec (input regs, input setting);
endinterface

/* File: src/pcrb_regfile.sv */
`timescale 1ns/1ps
module pcrb_regfile #(
  parameter int NREGS = pcrb_pkg::NUM_REGS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data_q,
  pcrb_cfg_if.bank cfg
);
  logic [7:0] mem_q [NREGS];
  localparam logic [7:0] RSTV [11] = '{
    pcrb_pkg::RST_ALT_N_HI, pcrb_pkg::RST_ALT_N_LO_R_HI,
    pcrb_pkg::RST_ALT_R_LO_Q_HI, pcrb_pkg::RST_ALT_Q_LO_P_BAND,
    pcrb_pkg::RST_SPREAD, pcrb_pkg::RST_SPREAD, pcrb_pkg::RST_SPREAD,
    pcrb_pkg::RST_FREQ_SEL, pcrb_pkg::RST_MUX_STATES,
    pcrb_pkg::RST_STATE_CHOICE, pcrb_pkg::RST_SPREAD_SHAPE};

  // Every byte reads back what was last written to it.
  always_ff @(posedge clk) begin
    for (int i = 0; i < NREGS; i++) begin
      if (srst) begin
        mem_q[i] <= RSTV[i];
      end else if (wr_en && wr_idx == 4'(i)) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= (rd_idx < 4'(NREGS)) ? mem_q[rd_idx] : 8'h00;
    end
  end

  assign cfg.regs = mem_q;
endmodule

/* File: src/pcrb_decode.sv */
`timescale 1ns/1ps
module pcrb_decode (
  pcrb_cfg_if.dec cfg,
  output logic [29:0] alt_word,
  output logic [1:0] alt_band,
  output logic [2:0] spread_amount,
  output logic freq_choice,
  output logic state_choice,
  output logic [1:0] active_state
);
  logic [23:0] spread_all;
  logic [7:0] mux_r;
  // Multi-byte fields assemble most significant byte first.
  assign alt_word = {cfg.regs[0], cfg.regs[1], cfg.regs[2], cfg.regs[3][7:2]};
  assign alt_band = cfg.regs[3][1:0];
  assign spread_all = {cfg.regs[4], cfg.regs[5], cfg.regs[6]};
  assign spread_amount = spread_all[3*cfg.setting +: 3];
  assign freq_choice = cfg.regs[7][cfg.setting];
  assign state_choice = cfg.regs[9][cfg.setting];
  assign mux_r = cfg.regs[8];
  assign active_state = state_choice ? mux_r[pcrb_pkg::STATE_ONE_LSB +: 2]
                                     : mux_r[pcrb_pkg::STATE_ZERO_LSB +: 2];
endmodule

/* File: tb/pcrb_top_chk.sv */
`timescale 1ns/1ps
module pcrb_top_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic setting_pin_zero,
  input wire logic setting_pin_one,
  input wire logic setting_pin_two,
  input wire logic [29:0] loop1_alt_word_q,
  input wire logic [1:0] loop1_alt_vco_band_q,
  input wire logic [7:0] loop1_alt_vco_min_mhz_q,
  input wire logic [2:0] loop2_spread_amount_q,
  input wire logic loop2_spread_shape_q,
  input wire logic [7:0] loop2_spread_quarter_pct_q,
  input wire logic loop2_freq_choice_q,
  input wire logic loop2_bypass_sel_q,
  input wire logic loop2_powered_q,
  input wire logic [3:0] out4_source_q,
  input wire logic [3:0] out5_source_q,
  input wire logic [3:0] pair_state_q,
  input wire logic pair_drive_en_q,
  input wire logic pair_drive_low_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_band_floor:
    assert property (loop1_alt_vco_min_mhz_q == (loop1_alt_vco_band_q == 2'h0 ? 8'h00
      : 8'h64 + 8'h19 * {6'h00, loop1_alt_vco_band_q})) else $error("band floor wrong");
  a_spread_pct:
    assert property (loop2_spread_quarter_pct_q == (loop2_spread_amount_q == 3'h7 ? 8'h08
      : {5'h00, loop2_spread_amount_q})) else $error("spread percent wrong");
  a_bypass_off:
    assert property (loop2_bypass_sel_q |-> !loop2_powered_q) else $error("bypassed loop on");
  a_hiz_down:
    assert property (pair_state_q == pcrb_pkg::ST_HIZ_DOWN |-> !loop2_powered_q
      && !pair_drive_en_q) else $error("hiz down state wrong");
  a_drive_low:
    assert property (pair_drive_low_q == (pair_state_q == pcrb_pkg::ST_LOW_RUN))
      else $error("drive low wrong");
  a_read_lat:
    assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read answer late");
  a_rdata_byte:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
  a_write_lat:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_ready_low:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during response");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_top_spread: cover property (loop2_spread_amount_q == 3'h7);
endmodule

bind pcrb_top pcrb_top_chk chk_u (.*);

/* File: tb/pcrb_host.sv */
`timescale 1ns/1ps
module pcrb_host (
  input wire logic clk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Response readies stay high, so no release can collide with the next request.
  initial begin
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw, t;
    pa = 1'b1;
    pw = 1'b1;
    t = 1'b0;
    r = pcrb_pkg::RESP_OKAY;
    if (a == 12'h090 && d[5:4] == pcrb_pkg::OUT5_RESERVED) return;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_awaddr <= ~a;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tw) s_axi_wdata <= ~{24'h00_0000, d};
      pa = pa && !ta;
      pw = pw && !tw;
    end
    while (!t) begin
      @(negedge clk);
      t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
    end
  endtask
endmodule

/* File: tb/test_pll_config_register_bank.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %0h want %0h", $time, got, exp); end end
module test_pll_config_register_bank;
  logic clk = 1'b0;
  logic srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb, out4_source_q, out5_source_q, pair_state_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, loop1_alt_vco_band_q, resp;
  logic setting_pin_zero, setting_pin_one, setting_pin_two;
  logic [29:0] loop1_alt_word_q;
  logic [7:0] loop1_alt_vco_min_mhz_q, loop2_spread_quarter_pct_q;
  logic [2:0] loop2_spread_amount_q;
  logic loop2_spread_shape_q, loop2_freq_choice_q, loop2_bypass_sel_q, loop2_powered_q;
  logic pair_drive_en_q, pair_drive_low_q;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] rv [11] = '{8'h00, 8'h40, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'hED,
    8'h02, 8'h00};
  logic [7:0] wv [11] = '{8'hAB, 8'hCD, 8'hEF, 8'h9E, 8'hFA, 8'hC6, 8'h88, 8'h5A, 8'h26,
    8'hA5, 8'h80};
  logic [7:0] mhz [4] = '{8'h00, 8'h7D, 8'h96, 8'hAF};
  logic [7:0] mv [4] = '{8'h26, 8'h4C, 8'h90, 8'h68};
  pcrb_top dut_u (.*);
  pcrb_host host_u (.*);
  always #2 clk = ~clk;
  function automatic logic [11:0] ad(input int i);
    return 12'((pcrb_pkg::FIRST_IDX + i) * 4);
  endfunction
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pins(input logic [2:0] k);
    @(posedge clk);
    {setting_pin_two, setting_pin_one, setting_pin_zero} <= k;
    settle;
  endtask
  task automatic finish_test;
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    srst = 1'b1;
    {setting_pin_two, setting_pin_one, setting_pin_zero} = 3'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    settle;
    `CHK(loop1_alt_word_q, {12'h004, 9'h000, 6'h10, 3'h2})
    `CHK(out4_source_q, pcrb_pkg::SRC_DIV_FOUR)
    `CHK(out5_source_q, pcrb_pkg::SRC_DIV_FIVE)
    `CHK(loop2_bypass_sel_q, 1'b1)
    `CHK(pair_state_q, pcrb_pkg::ST_HIZ_RUN)
    for (int i = 0; i < 11; i++) begin
      host_u.rd(ad(i), rdat, resp);
      `CHK(rdat, {24'h00_0000, rv[i]})
      `CHK(resp, pcrb_pkg::RESP_OKAY)
    end
    for (int i = 0; i < 11; i++) begin
      host_u.wr(ad(i), wv[i], resp);
      `CHK(resp, pcrb_pkg::RESP_OKAY)
      host_u.rd(ad(i), rdat, resp);
      `CHK(rdat, {24'h00_0000, wv[i]})
    end
    `CHK(loop1_alt_word_q, 30'(32'hABCD_EF9E >> 2))
    `CHK(loop2_spread_shape_q, 1'b1)
    for (int k = 0; k < 8; k++) begin
      pins(k[2:0]);
      `CHK(loop2_spread_amount_q, k[2:0])
      `CHK(loop2_spread_quarter_pct_q, k == 7 ? 8'h08 : 8'(k))
      `CHK(loop2_freq_choice_q, wv[7][k])
      `CHK(pair_state_q, wv[9][k] ? pcrb_pkg::ST_HIZ_RUN : pcrb_pkg::ST_LOW_RUN)
    end
    for (int b = 0; b < 4; b++) begin
      host_u.wr(ad(3), {6'h27, b[1:0]}, resp);
      settle;
      `CHK(loop1_alt_vco_band_q, b[1:0])
      `CHK(loop1_alt_vco_min_mhz_q, mhz[b])
    end
    for (int j = 0; j < 4; j++) begin
      host_u.wr(ad(8), mv[j], resp);
      pins(3'h0);
      `CHK(loop2_bypass_sel_q, mv[j][7])
      `CHK(out4_source_q, 4'h1 << mv[j][6])
      `CHK(out5_source_q, 4'h1 << mv[j][5:4])
      `CHK(pair_state_q, 4'h1 << mv[j][3:2])
      `CHK(pair_drive_en_q, mv[j][3])
      `CHK(pair_drive_low_q, mv[j][3:2] == 2'h2)
      `CHK(loop2_powered_q, !mv[j][7] && mv[j][3:2] != 2'h0)
      pins(3'h1);
      `CHK(pair_state_q, 4'h1 << mv[j][1:0])
    end
    host_u.wr(ad(10), 8'h00, resp);
    settle;
    `CHK(loop2_spread_shape_q, 1'b0)
    host_u.rd(12'h0A0, rdat, resp);
    `CHK(resp, pcrb_pkg::RESP_SLVERR)
    `CHK(rdat, 32'h0000_0000)
    host_u.wr(12'h071, 8'h11, resp);
    `CHK(resp, pcrb_pkg::RESP_SLVERR)
    finish_test;
  end
endmodule
